// ==== common/tlir_params.svh ====
// Offsets, field layouts, reset values of the interrupt router
`ifndef TLIR_PARAMS_SVH
`define TLIR_PARAMS_SVH
`define TLIR_OFF_NORMAL_PEND   12'h000
`define TLIR_OFF_MASK          12'h004
`define TLIR_OFF_ROUTE         12'h008
`define TLIR_OFF_IDLE_CTRL     12'h00C
`define TLIR_OFF_FAST_PEND     12'h010
`define TLIR_OFF_COMB_PEND     12'h014
`define TLIR_OFF_EVT_STATUS    12'h018
`define TLIR_OFF_EVT_MASK      12'h01C
`define TLIR_SRC_BITS          32'hFFFE7F00
`define TLIR_REG_RESET         32'h00000000
`define TLIR_IDLE_APPLY_BIT    0
`define TLIR_EVT_NORMAL_BIT    0
`define TLIR_EVT_FAST_BIT      1
`define TLIR_EVT_WAKE_BIT      2
`define TLIR_EVT_WIDTH         3
`endif

// ==== common/tlir_pkg.sv ====
// Types and helper functions of the interrupt router
package tlir_pkg;
  `include "tlir_params.svh"

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } tlir_apb_req_type;

  typedef struct packed {
    logic [31:0] mask;
    logic [31:0] route;
    logic        idle_apply;
  } tlir_ctrl_type;

  typedef struct packed {
    logic [31:0] normal;
    logic [31:0] fast;
    logic [31:0] comb;
  } tlir_pend_type;

  function automatic logic [31:0] tlir_src_only(input logic [31:0] v);
    tlir_src_only = v & `TLIR_SRC_BITS;
  endfunction : tlir_src_only

  function automatic logic tlir_addr_ok(input logic [11:0] a);
    tlir_addr_ok = (a == `TLIR_OFF_NORMAL_PEND) || (a == `TLIR_OFF_MASK)
                || (a == `TLIR_OFF_ROUTE) || (a == `TLIR_OFF_IDLE_CTRL)
                || (a == `TLIR_OFF_FAST_PEND) || (a == `TLIR_OFF_COMB_PEND)
                || (a == `TLIR_OFF_EVT_STATUS) || (a == `TLIR_OFF_EVT_MASK);
  endfunction : tlir_addr_ok
endpackage : tlir_pkg

// ==== core/tlir_apb_port.sv ====
// APB slave port: zero wait state, registered read data and error
`timescale 1ns/1ns
module tlir_apb_port
  import tlir_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire tlir_apb_req_type req,
  input  wire logic [31:0]      rd_data,
  output logic                  wr_en,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr
);
  logic        pready_r;
  logic        pready_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic        pslverr_r;
  logic        pslverr_nxt;
  logic        setup;

  always_comb
  begin
    setup       = req.psel && !req.penable;
    pready_nxt  = setup;
    prdata_nxt  = prdata_r;
    pslverr_nxt = 1'b0;
    if (setup)
    begin
      prdata_nxt  = (!req.pwrite && tlir_addr_ok(req.paddr)) ? rd_data : 32'h00000000;
      pslverr_nxt = !tlir_addr_ok(req.paddr);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h00000000;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r  <= pready_nxt;
      prdata_r  <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign wr_en   = req.psel && req.penable && pready_r && req.pwrite && !pslverr_r;
  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
endmodule : tlir_apb_port

// ==== core/tlir_route.sv ====
// Pending views and processor request lines
`timescale 1ns/1ns
module tlir_route
  import tlir_pkg::*;
(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic [31:0]   src_req,
  input  wire tlir_ctrl_type ctrl,
  output tlir_pend_type      pend,
  output logic               irq_out,
  output logic               fiq_out
);
  tlir_pend_type pend_r;
  tlir_pend_type pend_nxt;
  logic          irq_r;
  logic          irq_nxt;
  logic          fiq_r;
  logic          fiq_nxt;
  logic [31:0]   live;

  always_comb
  begin
    live            = tlir_src_only(src_req);
    pend_nxt.normal = live & ~ctrl.route;
    pend_nxt.fast   = live & ctrl.route;
    pend_nxt.comb   = pend_nxt.normal | pend_nxt.fast;
    irq_nxt         = |(pend_nxt.normal & ctrl.mask);
    fiq_nxt         = |(pend_nxt.fast & ctrl.mask);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pend_r <= '0;
      irq_r  <= 1'b0;
      fiq_r  <= 1'b0;
    end
    else
    begin
      pend_r <= pend_nxt;
      irq_r  <= irq_nxt;
      fiq_r  <= fiq_nxt;
    end
  end

  assign pend    = pend_r;
  assign irq_out = irq_r;
  assign fiq_out = fiq_r;
endmodule : tlir_route

// ==== core/tlir_top.sv ====
// Two-level interrupt router top with APB registers
`timescale 1ns/1ns
`include "tlir_params.svh"
module tlir_top
  import tlir_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [31:0] src_req,
  input  wire logic        idle_mode,
  output logic             normal_irq,
  output logic             fast_irq,
  output logic             wake_req,
  output logic             evt_irq
);
  tlir_apb_req_type req;
  tlir_ctrl_type    ctrl_r;
  tlir_ctrl_type    ctrl_nxt;
  tlir_pend_type    pend;
  logic             wr_en;
  logic [31:0]      rd_data;
  logic [`TLIR_EVT_WIDTH-1:0] evt_stat_r;
  logic [`TLIR_EVT_WIDTH-1:0] evt_stat_nxt;
  logic [`TLIR_EVT_WIDTH-1:0] evt_mask_r;
  logic [`TLIR_EVT_WIDTH-1:0] evt_mask_nxt;
  logic [`TLIR_EVT_WIDTH-1:0] evt_set;
  logic [`TLIR_EVT_WIDTH-1:0] evt_clr;
  logic             evt_irq_r;
  logic             evt_irq_nxt;
  logic             wake_r;
  logic             wake_nxt;
  logic [31:0]      prev_normal_r;
  logic [31:0]      prev_fast_r;
  logic             route_irq;
  logic             route_fiq;
  logic [31:0]      wake_srcs;
  logic [31:0]      prev_normal_nxt;
  logic [31:0]      prev_fast_nxt;
  logic             mask_wr;
  logic             route_wr;
  logic             idle_wr;
  logic             evt_stat_wr;
  logic             evt_mask_wr;

  // Write strobe of one register offset
  function automatic logic tlir_wr_hit(input logic en, input logic [11:0] a, input logic [11:0] off);
    tlir_wr_hit = en && (a == off);
  endfunction : tlir_wr_hit

  // Any bit set now that was clear before
  function automatic logic tlir_rise(input logic [31:0] now_v, input logic [31:0] was_v);
    tlir_rise = |(now_v & ~was_v);
  endfunction : tlir_rise

  // Bus request bundle
  always_comb
  begin
    req.psel    = psel;
    req.penable = penable;
    req.pwrite  = pwrite;
    req.paddr   = paddr;
    req.pwdata  = pwdata;
  end

  tlir_apb_port u_port
  (
    .pclk    (pclk),
    .presetn (presetn),
    .req     (req),
    .rd_data (rd_data),
    .wr_en   (wr_en),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr)
  );

  tlir_route u_route
  (
    .pclk    (pclk),
    .presetn (presetn),
    .src_req (src_req),
    .ctrl    (ctrl_r),
    .pend    (pend),
    .irq_out (route_irq),
    .fiq_out (route_fiq)
  );

  // Per-register write strobes
  always_comb
  begin
    mask_wr     = tlir_wr_hit(wr_en, paddr, `TLIR_OFF_MASK);
    route_wr    = tlir_wr_hit(wr_en, paddr, `TLIR_OFF_ROUTE);
    idle_wr     = tlir_wr_hit(wr_en, paddr, `TLIR_OFF_IDLE_CTRL);
    evt_stat_wr = tlir_wr_hit(wr_en, paddr, `TLIR_OFF_EVT_STATUS);
    evt_mask_wr = tlir_wr_hit(wr_en, paddr, `TLIR_OFF_EVT_MASK);
  end

  // Control register writes
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    if (mask_wr)
    begin
      ctrl_nxt.mask = tlir_src_only(pwdata);
    end
    if (route_wr)
    begin
      ctrl_nxt.route = tlir_src_only(pwdata);
    end
    if (idle_wr)
    begin
      ctrl_nxt.idle_apply = pwdata[`TLIR_IDLE_APPLY_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r.mask       <= `TLIR_REG_RESET;
      ctrl_r.route      <= `TLIR_REG_RESET;
      ctrl_r.idle_apply <= 1'b0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // Read mux
  always_comb
  begin
    case (paddr)
      `TLIR_OFF_NORMAL_PEND:
        rd_data = pend.normal;
      `TLIR_OFF_FAST_PEND:
        rd_data = pend.fast;
      `TLIR_OFF_COMB_PEND:
        rd_data = pend.comb;
      `TLIR_OFF_MASK:
        rd_data = ctrl_r.mask;
      `TLIR_OFF_ROUTE:
        rd_data = ctrl_r.route;
      `TLIR_OFF_IDLE_CTRL:
        rd_data = {31'h00000000, ctrl_r.idle_apply};
      `TLIR_OFF_EVT_STATUS:
        rd_data = {29'h00000000, evt_stat_r};
      `TLIR_OFF_EVT_MASK:
        rd_data = {29'h00000000, evt_mask_r};
      default:
        rd_data = 32'h00000000;
    endcase
  end

  // Idle wake qualification
  always_comb
  begin
    if (ctrl_r.idle_apply)
    begin
      wake_srcs = pend.comb & ctrl_r.mask;
    end
    else
    begin
      wake_srcs = pend.comb;
    end
    wake_nxt = idle_mode && (|wake_srcs);
  end

  // Wake request register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wake_r <= 1'b0;
    end
    else
    begin
      wake_r <= wake_nxt;
    end
  end

  // Pending history for rise detection
  always_comb
  begin
    prev_normal_nxt = pend.normal;
    prev_fast_nxt   = pend.fast;
  end

  // History registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prev_normal_r <= `TLIR_REG_RESET;
      prev_fast_r   <= `TLIR_REG_RESET;
    end
    else
    begin
      prev_normal_r <= prev_normal_nxt;
      prev_fast_r   <= prev_fast_nxt;
    end
  end

  // Rises of the normal and fast pending views and of wake
  always_comb
  begin
    evt_set                       = '0;
    evt_set[`TLIR_EVT_NORMAL_BIT] = tlir_rise(pend.normal, prev_normal_r);
    evt_set[`TLIR_EVT_FAST_BIT]   = tlir_rise(pend.fast, prev_fast_r);
    evt_set[`TLIR_EVT_WAKE_BIT]   = tlir_rise({31'h00000000, wake_nxt}, {31'h00000000, wake_r});
  end

  // Event mask next value
  always_comb
  begin
    evt_mask_nxt = evt_mask_r;
    if (evt_mask_wr)
    begin
      evt_mask_nxt = pwdata[`TLIR_EVT_WIDTH-1:0];
    end
  end

  // Event mask register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      evt_mask_r <= '0;
    end
    else
    begin
      evt_mask_r <= evt_mask_nxt;
    end
  end

  // Sticky event status, set wins over clear
  always_comb
  begin
    evt_clr = '0;
    if (evt_stat_wr)
    begin
      evt_clr = pwdata[`TLIR_EVT_WIDTH-1:0];
    end
    evt_stat_nxt = (evt_stat_r & ~evt_clr) | evt_set;
  end

  // Event status register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      evt_stat_r <= '0;
    end
    else
    begin
      evt_stat_r <= evt_stat_nxt;
    end
  end

  // Event interrupt level
  always_comb
  begin
    evt_irq_nxt = |(evt_stat_nxt & evt_mask_nxt);
  end

  // Event interrupt register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      evt_irq_r <= 1'b0;
    end
    else
    begin
      evt_irq_r <= evt_irq_nxt;
    end
  end

  // Both lines driven independently; the core ranks fast first
  assign normal_irq = route_irq;
  assign fast_irq   = route_fiq;
  assign wake_req   = wake_r;
  assign evt_irq    = evt_irq_r;
endmodule : tlir_top

// ==== sim/tlir_top_assertions.sv ====
// Port checks of the interrupt router
`timescale 1ns/1ns
module tlir_top_checker
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] src_req,
  input wire logic        idle_mode,
  input wire logic        normal_irq,
  input wire logic        fast_irq,
  input wire logic        wake_req
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  chk_ready_prompt: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_ready_once: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_err_unmapped: assert property (psel && !penable |=> pslverr == $past(paddr[1:0] != 2'h0 || paddr > 12'h01C))
    else $error("wrong error flag");
  chk_err_data: assert property (pslverr |-> prdata == 32'h0)
    else $error("read data on error");
  chk_irq_cause: assert property (normal_irq |-> ($past(src_req) & 32'hFFFE7F00) != 32'h0)
    else $error("normal request without source");
  chk_fiq_cause: assert property (fast_irq |-> ($past(src_req) & 32'hFFFE7F00) != 32'h0)
    else $error("fast request without source");
  chk_quiet_src: assert property ((src_req & 32'hFFFE7F00) == 32'h0 |=> (!normal_irq && !fast_irq) ##1 !wake_req)
    else $error("request held without source");
  chk_wake_idle: assert property (wake_req |-> $past(idle_mode))
    else $error("wake outside idle");
endmodule : tlir_top_checker
bind tlir_top tlir_top_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_req(src_req),
  .idle_mode(idle_mode), .normal_irq(normal_irq), .fast_irq(fast_irq), .wake_req(wake_req));

// ==== sim/tlir_core_model.sv ====
// Processor core model: request lines and idle state
`timescale 1ns/1ns
module tlir_core_model
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       normal_irq,
  input  wire logic       fast_irq,
  input  wire logic       idle_req,
  output logic            idle_mode,
  output logic [1:0]      taken
);
  // Fast request served first
  assign taken = fast_irq ? 2'h2 : {1'b0, normal_irq};
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      idle_mode <= 1'b0;
    else
      idle_mode <= idle_req;
endmodule : tlir_core_model

// ==== sim/tlir_top_tb.sv ====
// Self-checking bench of the interrupt router
`timescale 1ns/1ns
module tlir_top_tb;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, idle_req = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, src_req = 32'h0, prdata, q;
  logic        pready, pslverr, e, idle_mode, normal_irq, fast_irq, wake_req, evt_irq;
  logic [1:0]  taken;
  int          n_errors = 0, tests_run = 0;
  always #10 pclk = ~pclk;
  tlir_top i_tlir_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_req(src_req),
    .idle_mode(idle_mode), .normal_irq(normal_irq), .fast_irq(fast_irq), .wake_req(wake_req), .evt_irq(evt_irq));
  tlir_core_model i_tlir_core_model (.pclk(pclk), .presetn(presetn), .normal_irq(normal_irq),
    .fast_irq(fast_irq), .idle_req(idle_req), .idle_mode(idle_mode), .taken(taken));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rd
  task automatic clk(input int n);
    repeat (n) @(posedge pclk);
  endtask : clk
  task automatic t_reset;
    src_req <= 32'h00000100;
    clk(2);
    rd(12'h004, 32'h0);
    rd(12'h008, 32'h0);
    rd(12'h00C, 32'h0);
    rd(12'h000, 32'h00000100);
    chk(normal_irq, 1'b0);
  endtask : t_reset
  task automatic t_route;
    apb(1'b1, 12'h004, 32'h00020100);
    apb(1'b1, 12'h008, 32'h00020200);
    src_req <= 32'h00020300;
    clk(2);
    rd(12'h000, 32'h00000100);
    rd(12'h010, 32'h00020200);
    rd(12'h014, 32'h00020300);
    chk({normal_irq, fast_irq}, 2'h3);
    chk(taken, 2'h2);
    src_req <= 32'h00000300;
    clk(2);
    chk(fast_irq, 1'b0);
    rd(12'h010, 32'h00000200);
  endtask : t_route
  task automatic t_regs;
    apb(1'b1, 12'h004, 32'hFFFFFFFF);
    rd(12'h004, 32'hFFFE7F00);
    apb(1'b1, 12'h014, 32'hFFFFFFFF);
    rd(12'h014, 32'h00000300);
    apb(1'b1, 12'h020, 32'h1);
    chk(e, 1'b1);
    apb(1'b0, 12'h022, 32'h0);
    chk(32'(e), 32'h00000001);
    chk(q, 32'h00000000);
  endtask : t_regs
  task automatic t_idle;
    apb(1'b1, 12'h004, 32'h0);
    src_req <= 32'h00000400;
    idle_req <= 1'b1;
    clk(3);
    chk(wake_req, 1'b1);
    apb(1'b1, 12'h00C, 32'h1);
    clk(2);
    chk(wake_req, 1'b0);
    apb(1'b1, 12'h004, 32'h00000400);
    clk(2);
    chk(wake_req, 1'b1);
    idle_req <= 1'b0;
    src_req <= 32'h0;
  endtask : t_idle
  task automatic t_evt;
    clk(2);
    apb(1'b1, 12'h018, 32'h7);
    rd(12'h018, 32'h0);
    src_req <= 32'h00000100;
    clk(3);
    rd(12'h018, 32'h1);
    chk(evt_irq, 1'b0);
    apb(1'b1, 12'h01C, 32'h1);
    clk(2);
    chk(evt_irq, 1'b1);
    apb(1'b1, 12'h018, 32'h1);
    clk(2);
    chk(evt_irq, 1'b0);
  endtask : t_evt
  task automatic conclude;
    $display("mismatches %0d of %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude
  initial
  begin
    repeat (3000) @(posedge pclk);
    n_errors++;
    conclude;
  end
  initial
  begin
    clk(10);
    presetn <= 1'b1;
    t_reset;
    t_route;
    t_regs;
    t_idle;
    t_evt;
    conclude;
  end
endmodule : tlir_top_tb
